// ===== rtc_calendar.sv
// calendar clock core with wishbone register slave and time subtractor
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module rtc_calendar #(
    parameter int unsigned SEC_TICKS = rtc_pkg::SEC_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o
);
    import rtc_pkg::*;

    logic [15:0]        cal_reg [N_FIELDS];
    logic [15:0]        cal_next [N_FIELDS];
    logic [15:0]        mem_reg [DATA_WORDS];
    logic [15:0]        mem_next [DATA_WORDS];
    logic               yr_mode_reg;
    logic               yr_mode_next;
    logic               corr_reg;
    logic               corr_next;
    logic               corr_prev_reg;
    logic [ST_W-1:0]    status_reg;
    logic [ST_W-1:0]    status_next;
    logic [ST_W-1:0]    status_set;
    logic [ST_W-1:0]    mask_reg;
    logic [ST_W-1:0]    mask_next;
    logic [15:0]        errcode_reg;
    logic [15:0]        errcode_next;
    logic [31:0]        presc_reg;
    logic [31:0]        presc_next;
    logic               ack_reg;
    logic [31:0]        dat_reg;
    logic [31:0]        dat_next;

    logic               acc;
    logic               wr;
    logic               rd;
    logic               lane_wr;
    logic [15:0]        wval;
    logic               is_cal;
    logic               is_data;
    logic [2:0]         cal_idx;
    logic [DATA_AW-1:0] data_idx;
    logic               cmd_wr;
    cmd_op_t            op;
    logic [DATA_AW-1:0] ia [N_FIELDS];
    logic [DATA_AW-1:0] ib [3];
    logic [DATA_AW-1:0] ic [3];
    logic [N_FIELDS-1:0] blk_ok;
    logic [15:0]        blk_val [N_FIELDS];
    logic               reg_ok;
    logic               cal_load;
    logic               tick;
    logic               corr_edge;
    logic [15:0]        year_disp;
    logic [15:0]        dim;
    logic               carry;
    logic [15:0]        lim;
    logic [15:0]        res_h;
    logic [15:0]        res_m;
    logic [15:0]        res_s;
    logic               sub_err;
    logic               sub_borrow;
    logic               sub_zero;

    function automatic logic in_range(input int f, input logic [15:0] v);
        return (v >= FIELD_MIN[f]) && (v <= FIELD_MAX[f]);
    endfunction : in_range

    // days in month; every year divisible by four is leap in 2000..2099
    function automatic logic [15:0] month_days(input logic [15:0] m, input logic [15:0] y);
        case (m)
            16'h0004, 16'h0006, 16'h0009, 16'h000B: month_days = 16'h001E;
            16'h0002: month_days = (y[1:0] == 2'h0) ? 16'h001D : 16'h001C;
            default:  month_days = 16'h001F;
        endcase
    endfunction : month_days

    // bus decode; a request is taken once, the cycle before ack rises
    assign acc      = wb_cyc_i && wb_stb_i && !ack_reg && ce_i;
    assign wr       = acc && wb_we_i;
    assign rd       = acc && !wb_we_i;
    assign lane_wr  = |wb_sel_i[1:0];
    assign is_cal   = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[4:2] != 3'h7);
    assign is_data  = wb_adr_i[7:6] == DATA_PAGE;
    assign cal_idx  = wb_adr_i[4:2];
    assign data_idx = wb_adr_i[5:2];
    assign cmd_wr   = wr && (wb_adr_i == OFS_CMD) && lane_wr;
    assign op       = cmd_wr ? cmd_op_t'(wval[CMD_OP_LSB +: 2]) : OP_NONE;

    // byte-lane merge of write data into the addressed 16-bit word
    always_comb begin
        wval = is_cal ? cal_reg[cal_idx] : (is_data ? mem_reg[data_idx] : 16'h0000);
        if (wb_sel_i[0]) begin
            wval[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            wval[15:8] = wb_dat_i[15:8];
        end
    end

    // operand indices and clamped block-write values, one slice per field
    for (genvar g = 0; g < N_FIELDS; g++) begin : g_fld
        assign ia[g]      = wval[CMD_A_LSB +: DATA_AW] + DATA_AW'(g);
        assign blk_ok[g]  = in_range(g, mem_reg[ia[g]]);
        assign blk_val[g] = blk_ok[g] ? mem_reg[ia[g]] : FIELD_MIN[g];
        if (g < 3) begin : g_tri
            assign ib[g] = wval[CMD_B_LSB +: DATA_AW] + DATA_AW'(g);
            assign ic[g] = wval[CMD_C_LSB +: DATA_AW] + DATA_AW'(g);
        end
    end

    assign reg_ok    = in_range(int'(cal_idx), wval);
    assign cal_load  = (op == OP_BLOCK_WRITE) || (wr && is_cal && lane_wr);
    assign tick      = ce_i && (presc_reg == SEC_TICKS - 1);
    assign corr_edge = ce_i && corr_reg && !corr_prev_reg;
    assign dim       = month_days(cal_reg[F_MONTH], cal_reg[F_YEAR]);
    assign year_disp = yr_mode_reg ? cal_reg[F_YEAR] + YEAR_OFFSET
                                   : cal_reg[F_YEAR];
    assign irq_o     = |(status_reg & mask_reg);
    assign wb_ack_o  = ack_reg && ce_i;   // hidden while frozen so it is seen once
    assign wb_dat_o  = dat_reg;

    rtc_time_sub u_sub (
        .a_h_i       (mem_reg[ia[0]]),
        .a_m_i       (mem_reg[ia[1]]),
        .a_s_i       (mem_reg[ia[2]]),
        .b_h_i       (mem_reg[ib[0]]),
        .b_m_i       (mem_reg[ib[1]]),
        .b_s_i       (mem_reg[ib[2]]),
        .res_h_o     (res_h),
        .res_m_o     (res_m),
        .res_s_o     (res_s),
        .range_err_o (sub_err),
        .borrow_o    (sub_borrow),
        .zero_o      (sub_zero)
    );

    // core next state: timekeeping, register writes and commands
    always_comb begin
        cal_next     = cal_reg;
        mem_next     = mem_reg;
        yr_mode_next = yr_mode_reg;
        corr_next    = corr_reg;
        mask_next    = mask_reg;
        errcode_next = errcode_reg;
        status_set   = '0;
        carry        = 1'b0;
        lim          = 16'h0000;
        // a time write restarts the second so the new value holds a full second
        presc_next   = (tick || cal_load) ? 32'h0000_0000 : presc_reg + 32'h0000_0001;

        // correction takes the place of a tick landing in the same cycle
        if (corr_edge) begin
            carry = cal_reg[F_SECOND] >= HALF_MIN;
            cal_next[F_SECOND] = 16'h0000;
        end else if (tick) begin
            carry = cal_reg[F_SECOND] >= FIELD_MAX[F_SECOND];
            cal_next[F_SECOND] = carry ? 16'h0000 : cal_reg[F_SECOND] + 16'h0001;
            status_set[ST_SECOND] = 1'b1;
        end
        // ripple minute, hour, day with weekday, month and year
        for (int f = F_MINUTE; f >= F_YEAR; f--) begin
            if (carry && f != F_WEEKDAY) begin
                lim = (f == F_DAY) ? dim : FIELD_MAX[f];
                if (f == F_DAY) begin
                    cal_next[F_WEEKDAY] = (cal_reg[F_WEEKDAY] >= FIELD_MAX[F_WEEKDAY])
                        ? FIELD_MIN[F_WEEKDAY] : cal_reg[F_WEEKDAY] + 16'h0001;
                end
                carry = cal_reg[f] >= lim;
                cal_next[f] = carry ? FIELD_MIN[f] : cal_reg[f] + 16'h0001;
            end
        end

        // plain register writes
        if (wr && is_cal && lane_wr) begin
            cal_next[cal_idx] = reg_ok ? wval : FIELD_MIN[cal_idx];
            if (!reg_ok) begin
                status_set[ST_ERR_A] = 1'b1;
                status_set[ST_ERR_B] = 1'b1;
                errcode_next = ERR_RANGE_CODE;
            end
        end
        if (wr && is_data && lane_wr) begin
            mem_next[data_idx] = wval;
        end
        if (wr && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
            yr_mode_next = wb_dat_i[CTRL_YEAR_MODE];
            corr_next    = wb_dat_i[CTRL_CORR];
        end
        if (wr && wb_adr_i == OFS_MASK && wb_sel_i[0]) begin
            mask_next = wb_dat_i[ST_W-1:0];
        end
        if (wr && wb_adr_i == OFS_ERRCODE && lane_wr) begin
            errcode_next = 16'h0000;
        end

        // commands
        case (op)
            OP_BLOCK_READ: begin
                for (int i = 0; i < N_FIELDS; i++) begin
                    mem_next[ia[i]] = (i == F_YEAR) ? year_disp : cal_reg[i];
                end
            end
            OP_BLOCK_WRITE: begin
                // year source is always two digits, whatever the display mode
                for (int i = 0; i < N_FIELDS; i++) begin
                    cal_next[i] = blk_val[i];
                end
                if (!(&blk_ok)) begin
                    status_set[ST_ERR_A] = 1'b1;
                    status_set[ST_ERR_B] = 1'b1;
                    errcode_next = ERR_RANGE_CODE;
                end
            end
            OP_SUBTRACT: begin
                if (sub_err) begin
                    status_set[ST_ERR_A] = 1'b1;
                    status_set[ST_ERR_B] = 1'b1;
                    errcode_next = ERR_RANGE_CODE;
                end else begin
                    mem_next[ic[0]] = res_h;
                    mem_next[ic[1]] = res_m;
                    mem_next[ic[2]] = res_s;
                    status_set[ST_BORROW] = sub_borrow;
                    status_set[ST_ZERO]   = sub_zero;
                end
            end
            default: begin
            end
        endcase

        // write one to clear; a new event in the same cycle wins
        status_next = status_reg & ~((wr && wb_adr_i == OFS_STATUS && wb_sel_i[0])
                                     ? wb_dat_i[ST_W-1:0] : '0);
        status_next = status_next | status_set;
    end

    // core registers; the calendar advances on ticks and corrections, is loaded by writes, and reset sets each field to its minimum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N_FIELDS; i++) begin
                cal_reg[i] <= FIELD_MIN[i];
            end
            for (int i = 0; i < DATA_WORDS; i++) begin
                mem_reg[i] <= 16'h0000;
            end
            yr_mode_reg   <= 1'b0;
            corr_reg      <= 1'b0;
            corr_prev_reg <= 1'b0;
            status_reg    <= '0;
            mask_reg      <= '0;
            errcode_reg   <= 16'h0000;
            presc_reg     <= 32'h0000_0000;
        end else if (ce_i) begin
            cal_reg       <= cal_next;
            mem_reg       <= mem_next;
            yr_mode_reg   <= yr_mode_next;
            corr_reg      <= corr_next;
            corr_prev_reg <= corr_reg;
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            errcode_reg   <= errcode_next;
            presc_reg     <= presc_next;
        end
    end

    // bus answer; unmapped reads return zero, unmapped writes are dropped
    always_comb begin
        dat_next = dat_reg;
        if (rd) begin
            dat_next = 32'h0000_0000;
            if (is_cal) begin
                dat_next[15:0] = (cal_idx == 3'(F_YEAR)) ? year_disp
                                                        : cal_reg[cal_idx];
            end else if (is_data) begin
                dat_next[15:0] = mem_reg[data_idx];
            end else if (wb_adr_i == OFS_CTRL) begin
                dat_next[CTRL_YEAR_MODE] = yr_mode_reg;
                dat_next[CTRL_CORR]      = corr_reg;
            end else if (wb_adr_i == OFS_STATUS) begin
                dat_next[ST_W-1:0] = status_reg;
            end else if (wb_adr_i == OFS_MASK) begin
                dat_next[ST_W-1:0] = mask_reg;
            end else if (wb_adr_i == OFS_ERRCODE) begin
                dat_next[15:0] = errcode_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= acc;
            dat_reg <= dat_next;
        end
    end

    // checks
    a_sub_result_store: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_SUBTRACT && !sub_err) |=> mem_reg[$past(ic[0])] == $past(res_h)
        && mem_reg[$past(ic[2])] == $past(res_s))
        else $error("subtract result not stored");
    a_sub_range_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_SUBTRACT && sub_err) |=> errcode_reg == ERR_RANGE_CODE
        && status_reg[ST_ERR_A] && status_reg[ST_ERR_B])
        else $error("subtract range error not reported");
    a_sub_borrow_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_SUBTRACT && !sub_err && sub_borrow) |=> status_reg[ST_BORROW]
        && mem_reg[$past(ic[0])] <= FIELD_MAX[F_HOUR])
        else $error("borrow not flagged or hour out of range");
    a_sub_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_SUBTRACT && !sub_err && sub_zero) |=> status_reg[ST_ZERO])
        else $error("zero result not flagged");
    a_hour_direct_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i == OFS_HOUR) |=> wb_ack_o && wb_dat_o == {16'h0000,
        $past(cal_reg[F_HOUR])})
        else $error("hour read mismatch");
    a_block_read_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_BLOCK_READ) |=> mem_reg[$past(ia[0])] == $past(year_disp)
        && mem_reg[$past(ia[6])] == $past(cal_reg[F_SECOND]))
        else $error("block read order wrong");
    a_weekday_range: assert property (@(posedge clk_i) disable iff (rst_i)
        cal_reg[F_WEEKDAY] >= 16'h0001 && cal_reg[F_WEEKDAY] <= 16'h0007)
        else $error("weekday out of range");
    a_field_ranges: assert property (@(posedge clk_i) disable iff (rst_i)
        cal_reg[F_SECOND] <= FIELD_MAX[F_SECOND] && cal_reg[F_HOUR] <= FIELD_MAX[F_HOUR]
        && cal_reg[F_MONTH] >= 16'h0001 && cal_reg[F_DAY] >= 16'h0001)
        else $error("calendar field out of range");
    a_year_display: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i == OFS_YEAR && yr_mode_reg) |=>
        wb_dat_o[15:0] == $past(cal_reg[F_YEAR]) + YEAR_OFFSET)
        else $error("year display offset wrong");
    a_half_min_corr: assert property (@(posedge clk_i) disable iff (rst_i)
        (corr_edge && !cal_load && cal_reg[F_SECOND] >= HALF_MIN
        && cal_reg[F_MINUTE] < FIELD_MAX[F_MINUTE]) |=> cal_reg[F_SECOND] == 16'h0000
        && cal_reg[F_MINUTE] == $past(cal_reg[F_MINUTE]) + 16'h0001)
        else $error("half minute correction wrong");
    a_block_write_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_BLOCK_WRITE) |=> cal_reg[F_HOUR] == $past(blk_val[F_HOUR]))
        else $error("block write not loaded");
    a_write_clamp_min: assert property (@(posedge clk_i) disable iff (rst_i)
        (op == OP_BLOCK_WRITE && !blk_ok[F_MONTH]) |=> cal_reg[F_MONTH] == 16'h0001
        && errcode_reg == ERR_RANGE_CODE)
        else $error("bad month not clamped");
    a_tick_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && !corr_edge && !cal_load && cal_reg[F_SECOND] == FIELD_MAX[F_SECOND]
        && cal_reg[F_MINUTE] < FIELD_MAX[F_MINUTE]) |=> cal_reg[F_SECOND] == 16'h0000
        && cal_reg[F_MINUTE] == $past(cal_reg[F_MINUTE]) + 16'h0001)
        else $error("second carry wrong");
endmodule : rtc_calendar

// ===== rtc_pkg.sv
// shared constants, register map and field layout of the calendar clock
//
// Overview of operation
// - subtract second time triple from first, store
// - operand out of range: both errors, code
// - negative difference: borrow flag, add 24 hours
// - result 00:00:00 sets the zero flag
// - hour, minute, second readable as plain registers
// - block read copies seven fields in order
// - calendar held; software rewrites time at power-up
// - weekday runs 1 Monday to 7 Sunday
// - every calendar field kept inside its range
// - year display mode adds 2000 on read
// - correction edge rounds seconds to nearest minute
// - block write loads seven fields from source
// - bad written value: minimum, errors, code
package rtc_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_YEAR    = 8'h00;
    localparam logic [7:0] OFS_HOUR    = 8'h10;
    localparam logic [7:0] OFS_CTRL    = 8'h1C;
    localparam logic [7:0] OFS_CMD     = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;
    localparam logic [7:0] OFS_MASK    = 8'h28;
    localparam logic [7:0] OFS_ERRCODE = 8'h2C;
    localparam logic [1:0] DATA_PAGE   = 2'h1;    // data words at 8'h40..8'h7C

    // calendar field index, block order
    localparam int F_YEAR    = 0;
    localparam int F_WEEKDAY = 1;
    localparam int F_MONTH   = 2;
    localparam int F_DAY     = 3;
    localparam int F_HOUR    = 4;
    localparam int F_MINUTE  = 5;
    localparam int F_SECOND  = 6;
    localparam int N_FIELDS  = 7;

    // legal ranges, element 0 is the year
    localparam logic [6:0][15:0] FIELD_MIN = {16'h0000, 16'h0000, 16'h0000, 16'h0001,
                                              16'h0001, 16'h0001, 16'h0000};
    localparam logic [6:0][15:0] FIELD_MAX = {16'h003B, 16'h003B, 16'h0017, 16'h001F,
                                              16'h000C, 16'h0007, 16'h0063};

    localparam logic [15:0] YEAR_OFFSET    = 16'h07D0;
    localparam logic [15:0] HALF_MIN       = 16'h001E;
    localparam logic [15:0] ERR_RANGE_CODE = 16'h0E1A;
    localparam logic [31:0] SECS_PER_HOUR  = 32'h0000_0E10;
    localparam logic [31:0] SECS_PER_MIN   = 32'h0000_003C;
    localparam logic [31:0] SECS_PER_DAY   = 32'h0001_5180;

    // scratch data words
    localparam int DATA_WORDS = 16;
    localparam int DATA_AW    = 4;

    // control bits
    localparam int CTRL_YEAR_MODE = 0;
    localparam int CTRL_CORR      = 1;

    // command fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_A_LSB  = 4;
    localparam int CMD_B_LSB  = 8;
    localparam int CMD_C_LSB  = 12;

    // status and mask bits
    localparam int ST_ERR_A  = 0;
    localparam int ST_ERR_B  = 1;
    localparam int ST_ZERO   = 2;
    localparam int ST_BORROW = 3;
    localparam int ST_SECOND = 4;
    localparam int ST_W      = 5;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_BLOCK_READ,
        OP_BLOCK_WRITE,
        OP_SUBTRACT
    } cmd_op_t;
endpackage : rtc_pkg

// ===== rtc_time_sub.sv
// hour-minute-second subtractor with borrow, zero and range check
`timescale 1ns/1ps
module rtc_time_sub (
    input  wire logic [15:0] a_h_i,
    input  wire logic [15:0] a_m_i,
    input  wire logic [15:0] a_s_i,
    input  wire logic [15:0] b_h_i,
    input  wire logic [15:0] b_m_i,
    input  wire logic [15:0] b_s_i,
    output logic      [15:0] res_h_o,
    output logic      [15:0] res_m_o,
    output logic      [15:0] res_s_o,
    output logic             range_err_o,
    output logic             borrow_o,
    output logic             zero_o
);
    import rtc_pkg::*;

    logic [31:0] t_a;
    logic [31:0] t_b;
    logic [31:0] diff;
    logic [31:0] rem;

    // operand check on both triples
    assign range_err_o = (a_h_i > FIELD_MAX[F_HOUR]) || (a_m_i > FIELD_MAX[F_MINUTE])
                      || (a_s_i > FIELD_MAX[F_SECOND]) || (b_h_i > FIELD_MAX[F_HOUR])
                      || (b_m_i > FIELD_MAX[F_MINUTE]) || (b_s_i > FIELD_MAX[F_SECOND]);

    // work in seconds of the day, so one borrow covers all three fields
    assign t_a = 32'(a_h_i) * SECS_PER_HOUR + 32'(a_m_i) * SECS_PER_MIN + 32'(a_s_i);
    assign t_b = 32'(b_h_i) * SECS_PER_HOUR + 32'(b_m_i) * SECS_PER_MIN + 32'(b_s_i);
    assign borrow_o = t_a < t_b;
    assign diff = borrow_o ? t_a - t_b + SECS_PER_DAY : t_a - t_b;
    assign zero_o = diff == 32'h0000_0000;

    // split back into the result triple
    assign rem     = diff % SECS_PER_HOUR;
    assign res_h_o = 16'(diff / SECS_PER_HOUR);
    assign res_m_o = 16'(rem / SECS_PER_MIN);
    assign res_s_o = 16'(rem % SECS_PER_MIN);
endmodule : rtc_time_sub

// ===== test_rtc_calendar.sv
// self-checking bench for the calendar clock over its wishbone registers
`timescale 1ns/1ps
module test_rtc_calendar;
    import rtc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [31:0] q;
    logic [31:0] seed = 32'h0000_004D;
    logic [47:0] last_r = 48'h0;
    // block write source, block read and carry expectations in block order
    int          bw_val[7] = '{4, 3, 12, 31, 23, 59, 59};
    int          br_exp[7] = '{2004, 3, 12, 31, 23, 59, 59};
    int          cy_exp[7] = '{2005, 4, 1, 1, 0, 0, 0};
    int          num_errors = 0;
    int          checked = 0;
    // short second so carries show within a few hundred cycles
    rtc_calendar #(.SEC_TICKS(200)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
    always #5 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // expected difference of two triples, wrapped into one day
    function automatic logic [47:0] exp_sub(input int ah, am, as, bh, bm, bs);
        int d;
        d = (ah - bh) * 3600 + (am - bm) * 60 + (as - bs);
        if (d < 0) d += 86400;
        return {16'(d / 3600), 16'((d / 60) % 60), 16'(d % 60)};
    endfunction : exp_sub
    task automatic summarize();
        if (num_errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {16'h0000, d};
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            summarize();
        end
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 16'h0000);
        chk(name, e, q);
    endtask : rd
    task automatic do_sub(input int ah, am, as, bh, bm, bs);
        logic [47:0] r;
        logic        err;
        int          i;
        int          ta;
        int          tb;
        int          v[6];
        v = '{ah, am, as, bh, bm, bs};
        err = ah > 23 || am > 59 || as > 59 || bh > 23 || bm > 59 || bs > 59;
        ta = ah * 3600 + am * 60 + as;
        tb = bh * 3600 + bm * 60 + bs;
        for (i = 0; i < 6; i++) wb(1'b1, 8'h40 + 8'(4 * i), 16'(v[i]));
        wb(1'b1, OFS_STATUS, 16'h001F);
        wb(1'b1, OFS_CMD, 16'h6303);
        // a refused operand leaves the destination words as they were
        r = err ? last_r : exp_sub(ah, am, as, bh, bm, bs);
        last_r = r;
        rd("sub hour", 8'h58, {16'h0000, r[47:32]});
        rd("sub minute", 8'h5C, {16'h0000, r[31:16]});
        rd("sub second", 8'h60, {16'h0000, r[15:0]});
        wb(1'b0, OFS_STATUS, 16'h0000);
        chk("borrow", 32'(!err && ta < tb), q[3]);
        chk("zero", 32'(!err && r == 48'h0), q[2]);
        chk("sub flags", err ? 32'h3 : 32'h0, 32'(q[1:0]));
    endtask : do_sub
    // watchdog: the whole sequence needs about 2,000 cycles, so allow ten times that
    initial begin
        #200_000;
        num_errors++;
        summarize();
    end
    initial begin
        int k;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd("reset weekday", 8'h04, 32'h0000_0001);
        rd("reset month", 8'h08, 32'h0000_0001);
        rd("reset day", 8'h0C, 32'h0000_0001);
        do_sub(5, 6, 7, 5, 6, 7);
        do_sub(0, 0, 0, 0, 0, 1);
        for (k = 0; k < 12; k++) begin
            do_sub(xs() % 24, xs() % 60, xs() % 60, xs() % 24, xs() % 60, xs() % 60);
        end
        // interrupt: zero flag unmasked, then cleared
        wb(1'b1, OFS_MASK, 16'h0004);
        do_sub(1, 2, 3, 1, 2, 3);
        chk("irq set", 32'h1, irq_o);
        wb(1'b1, OFS_STATUS, 16'h0004);
        chk("irq clear", 32'h0, irq_o);
        wb(1'b1, OFS_MASK, 16'h0000);
        // operand out of range: error code, both flags
        wb(1'b1, OFS_ERRCODE, 16'h0000);
        do_sub(25, 0, 0, 1, 0, 0);
        rd("sub errcode", OFS_ERRCODE, {16'h0000, ERR_RANGE_CODE});
        wb(1'b0, OFS_STATUS, 16'h0000);
        chk("sub errflags", 32'h3, q[1:0]);
        // four-digit view on first: software still hands over a two-digit year
        wb(1'b1, OFS_CTRL, 16'h0001);
        for (k = 0; k < 7; k++) wb(1'b1, 8'h40 + 8'(4 * k), 16'(bw_val[k]));
        wb(1'b1, OFS_CMD, 16'h0002);
        wb(1'b1, OFS_CMD, 16'h0081);
        for (k = 0; k < 7; k++) rd("block read", 8'h60 + 8'(4 * k), br_exp[k]);
        // one second later everything rolls over into the new year
        repeat (250) @(posedge clk_i);
        for (k = 0; k < 7; k++) rd("carry", 8'(4 * k), cy_exp[k]);
        // correction edge with seconds in the upper half
        wb(1'b1, 8'h18, 16'h002D);
        wb(1'b1, OFS_CTRL, 16'h0003);
        rd("corr minute", 8'h14, 32'h0000_0001);
        rd("corr second", 8'h18, 32'h0000_0000);
        // seconds at the top with minutes below theirs: one tick carries
        wb(1'b1, 8'h18, 16'h003B);
        repeat (250) @(posedge clk_i);
        rd("tick minute", 8'h14, 32'h0000_0002);
        rd("tick second", 8'h18, 32'h0000_0000);
        // illegal hour stores its minimum and flags the error
        wb(1'b1, OFS_ERRCODE, 16'h0000);
        wb(1'b1, OFS_HOUR, 16'h0018);
        rd("clamp hour", OFS_HOUR, 32'h0000_0000);
        rd("clamp errcode", OFS_ERRCODE, {16'h0000, ERR_RANGE_CODE});
        // block write with month 13: that field takes its minimum, error recorded
        bw_val[F_MONTH] = 13;
        for (k = 0; k < 7; k++) wb(1'b1, 8'h40 + 8'(4 * k), 16'(bw_val[k]));
        wb(1'b1, OFS_ERRCODE, 16'h0000);
        wb(1'b1, OFS_CMD, 16'h0002);
        rd("clamp month", 8'h08, 32'h0000_0001);
        rd("block errcode", OFS_ERRCODE, {16'h0000, ERR_RANGE_CODE});
        rd("block hour", OFS_HOUR, 32'h0000_0017);
        // frozen clock enable: longer than a second, yet the time stays put
        wb(1'b1, 8'h18, 16'h000A);
        ce <= 1'b0;
        repeat (300) @(posedge clk_i);
        ce <= 1'b1;
        @(posedge clk_i);
        rd("frozen second", 8'h18, 32'h0000_000A);
        summarize();
    end
endmodule : test_rtc_calendar
